// ==== see_pkg.sv ====
`default_nettype none

package see_pkg;

   // ********************************************
   // framing and device address
   // ********************************************
   localparam int unsigned BYTE_BITS = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
   localparam logic [2:0] DEV_SEL_CODE = 3'h0;
   localparam logic [6:0] DEV_ADDR_CODE = {DEV_TYPE_CODE, DEV_SEL_CODE};

   // ********************************************
   // array and address counter
   // ********************************************
   localparam int unsigned MEM_BYTES = 128;
   localparam int unsigned IDX_W = 7;
   localparam logic [6:0] IDX_RST = 7'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam int unsigned PAGE_BYTES_DEF = 8;

   // ********************************************
   // timing
   // ********************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned PROG_TIME_NS_DEF = 2000000;
   localparam logic [31:0] TMR_RST = 32'h0000_0000;

   // least time in ns to whole clock cycles, at least one
   function automatic int unsigned cycles_up(input int unsigned t_ns);
      int unsigned n;
      n = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (n < 1) ? 1 : n;
   endfunction

   // ********************************************
   // link sequencer states
   // ********************************************
   typedef enum logic [5:0]
   {
      SEE_ST_IDLE = 6'h01,
      SEE_ST_DEV = 6'h02,
      SEE_ST_ADDR = 6'h04,
      SEE_ST_DATA = 6'h08,
      SEE_ST_RD = 6'h10,
      SEE_ST_MACK = 6'h20
   } see_state_e;

endpackage

`default_nettype wire

// ==== see_prog.sv ====
`timescale 1ns/1ps
`default_nettype none

module see_prog
#(
   parameter int unsigned PROG_CYCLES = 4
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic scl_pin,
   input wire logic sda_pin,
   input wire logic wr_tog,
   input wire logic [6:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [6:0] rd_idx,
   output logic [7:0] rd_data,
   output logic busy,
   output logic seen
);

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
      logic tog_s1;
      logic tog_s2;
      logic busy;
      logic seen;
      logic [31:0] tmr;
      logic [see_pkg::MEM_BYTES-1:0][7:0] mem;
   } see_prog_s;

   see_prog_s q;
   see_prog_s d;
   logic stop_w;
   logic commit_w;

   // ********************************************
   // stop detect, commit and programming timer
   // ********************************************
   always_comb
   begin
      d = q;
      d.scl_s1 = scl_pin;
      d.scl_s2 = q.scl_s1;
      d.scl_s3 = q.scl_s2;
      d.sda_s1 = sda_pin;
      d.sda_s2 = q.sda_s1;
      d.sda_s3 = q.sda_s2;
      d.tog_s1 = wr_tog;
      d.tog_s2 = q.tog_s1;
      stop_w = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3; // RQ21
      commit_w = stop_w & (q.tog_s2 != q.seen) & ~q.busy; // RQ9
      if (commit_w)
      begin
         d.mem[wr_addr] = wr_data; // RQ10
         d.busy = 1'b1;
         d.seen = q.tog_s2;
         d.tmr = 32'(PROG_CYCLES - 1); // RQ24
      end
      else if (q.busy)
      begin
         if (q.tmr == see_pkg::TMR_RST)
            d.busy = 1'b0;
         else
            d.tmr = q.tmr - 32'h1;
      end
   end

   // state register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         q <= '0;
      else
         q <= d;
   end

   // array read by index, stable while the link may look at it
   assign rd_data = q.mem[rd_idx]; // RQ22
   assign busy = q.busy;
   assign seen = q.seen;

   // ********************************************
   // checks
   // ********************************************
   chk_commit_write: assert property ( // RQ10
      @(posedge clock) disable iff (rst)
      commit_w |=> q.busy && (q.mem[$past(wr_addr)] == $past(wr_data)))
      else $error("stop after write did not program the byte");

   chk_busy_count: assert property ( // RQ10
      @(posedge clock) disable iff (rst)
      (q.busy && (q.tmr != see_pkg::TMR_RST)) |=> q.busy && (q.tmr == $past(q.tmr) - 32'h1))
      else $error("programming cycle ended early");

   chk_busy_end: assert property ( // RQ11
      @(posedge clock) disable iff (rst)
      (q.busy && (q.tmr == see_pkg::TMR_RST)) |=> !q.busy)
      else $error("busy held past programming time");

endmodule

`default_nettype wire

// ==== see_eeprom.sv ====
`timescale 1ns/1ps
`default_nettype none

// Function
// (RQ1) addresses and data move as bytes
// (RQ2) slave pulls data low on ninth clock
// (RQ3) master sends device address after start
// (RQ4) address top nibble is one zero one zero
// (RQ5) next three address bits are zero
// (RQ6) last address bit high reads, low writes
// (RQ7) match acknowledges, mismatch returns to idle
// (RQ8) write takes word address then data
// (RQ9) data byte acknowledged, master then stops
// (RQ10) stop starts timed programming, inputs ignored
// (RQ11) address not acknowledged while still busy
// (RQ12) current, random and sequential reads supported
// (RQ13) counter holds last address plus one
// (RQ14) read counter wraps over whole array
// (RQ15) write counter wraps within its page
// (RQ16) current read shifts out counter byte
// (RQ17) random read uses dummy write first
// (RQ18) master acknowledge advances to next byte
// (RQ19) master ends reads with nack, stop
// (RQ20) sample on rising, drive after falling
// (RQ21) sda edges with scl high frame
// (RQ22) array of 128 bytes, byte address
// (RQ23) stop after read returns to standby
// (RQ24) page size and programming time parameters
// (RQ25) slave only pulls low or releases
module see_eeprom
#(
   parameter int unsigned PROG_TIME_NS = see_pkg::PROG_TIME_NS_DEF,
   parameter int unsigned PAGE_BYTES = see_pkg::PAGE_BYTES_DEF
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic busy
);

   // ********************************************
   // types and constants
   // ********************************************
   localparam int unsigned PROG_CYCLES = see_pkg::cycles_up(PROG_TIME_NS); // RQ24
   localparam logic [6:0] PAGE_MASK = 7'(PAGE_BYTES - 1); // RQ24

   typedef struct packed {
      see_pkg::see_state_e st;
      logic [2:0] bit_n;
      logic ack_ph;
      logic [7:0] sh;
      logic [6:0] ptr;
      logic drive;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
      logic wr_tog;
      logic busy_s1;
      logic busy_s2;
      logic seen_s1;
      logic seen_s2;
   } see_link_s;

   localparam see_link_s LINK_RST = '{
      st: see_pkg::SEE_ST_IDLE,
      bit_n: 3'h0,
      ack_ph: 1'b0,
      sh: see_pkg::BYTE_RST,
      ptr: see_pkg::IDX_RST,
      drive: 1'b0,
      wr_addr: see_pkg::IDX_RST,
      wr_data: see_pkg::BYTE_RST,
      wr_tog: 1'b0,
      busy_s1: 1'b0,
      busy_s2: 1'b0,
      seen_s1: 1'b0,
      seen_s2: 1'b0
   };

   // ********************************************
   // helpers
   // ********************************************
   // next address inside the same page
   function automatic logic [6:0] page_inc(input logic [6:0] a);
      logic [6:0] n;
      n = a + 7'h01;
      return (a & ~PAGE_MASK) | (n & PAGE_MASK); // RQ15
   endfunction

   // start shifting a fresh byte out and advance the counter
   function automatic see_link_s load_byte(input see_link_s s, input logic [7:0] b);
      see_link_s r;
      r = s;
      r.st = see_pkg::SEE_ST_RD;
      r.sh = b; // RQ16
      r.ptr = s.ptr + 7'h01; // RQ13 RQ14
      r.drive = ~b[7]; // RQ25
      r.bit_n = 3'h0;
      r.ack_ph = 1'b0;
      return r;
   endfunction

   // ********************************************
   // signals
   // ********************************************
   see_link_s q;
   see_link_s d;
   logic sda_rise_q;
   logic start_w;
   logic stop_w;
   logic quiet_w;
   logic busy_link;
   logic dev_match;
   logic [7:0] rx_byte;
   logic [7:0] rd_data;
   logic busy_sys;
   logic seen_sys;

   // ********************************************
   // system side: stop detect, array, programming
   // ********************************************
   see_prog #(
      .PROG_CYCLES(PROG_CYCLES)
   ) u_prog (
      .clock(clock),
      .rst(rst),
      .scl_pin(scl),
      .sda_pin(sda_i),
      .wr_tog(q.wr_tog),
      .wr_addr(q.wr_addr),
      .wr_data(q.wr_data),
      .rd_idx(q.ptr),
      .rd_data(rd_data),
      .busy(busy_sys),
      .seen(seen_sys)
   );

   // ********************************************
   // link side: bit sampling on the rising edge
   // ********************************************
   always_ff @(posedge scl or posedge rst)
   begin
      if (rst)
         sda_rise_q <= 1'b1;
      else
         sda_rise_q <= sda_i; // RQ20
   end

   // frame edges seen between rising and falling scl
   assign start_w = sda_rise_q & ~sda_i; // RQ21
   assign stop_w = ~sda_rise_q & sda_i; // RQ21
   assign quiet_w = ~start_w & ~stop_w;
   assign rx_byte = {q.sh[6:0], sda_rise_q}; // RQ1
   assign busy_link = q.busy_s2 | (q.wr_tog != q.seen_s2); // RQ10 RQ11
   assign dev_match = (rx_byte[7:1] == see_pkg::DEV_ADDR_CODE); // RQ4 RQ5

   // ********************************************
   // link sequencer, steps on the falling edge
   // ********************************************
   always_comb
   begin
      d = q;
      // level crossings from the system clock
      d.busy_s1 = busy_sys;
      d.busy_s2 = q.busy_s1;
      d.seen_s1 = seen_sys;
      d.seen_s2 = q.seen_s1;
      if (start_w)
      begin
         d.st = see_pkg::SEE_ST_DEV; // RQ3 RQ21
         d.bit_n = 3'h0;
         d.ack_ph = 1'b0;
         d.drive = 1'b0;
      end
      else if (stop_w)
      begin
         d.st = see_pkg::SEE_ST_IDLE; // RQ23
         d.ack_ph = 1'b0;
         d.drive = 1'b0;
      end
      else
      begin
         unique case (q.st)
            see_pkg::SEE_ST_IDLE:
            begin
               d.drive = 1'b0;
            end
            see_pkg::SEE_ST_DEV, see_pkg::SEE_ST_ADDR, see_pkg::SEE_ST_DATA:
            begin
               if (q.ack_ph)
               begin
                  // ninth clock over: release and move on
                  d.ack_ph = 1'b0;
                  d.drive = 1'b0;
                  d.bit_n = 3'h0;
                  if (q.st == see_pkg::SEE_ST_DEV && q.sh[0])
                     d = load_byte(d, rd_data); // RQ6 RQ12 RQ16
                  else if (q.st == see_pkg::SEE_ST_DEV)
                     d.st = see_pkg::SEE_ST_ADDR; // RQ6 RQ8
                  else if (q.st == see_pkg::SEE_ST_ADDR)
                     d.st = see_pkg::SEE_ST_DATA; // RQ8 RQ17
                  else
                     d.st = see_pkg::SEE_ST_IDLE; // RQ9
               end
               else
               begin
                  d.sh = rx_byte; // RQ1
                  d.bit_n = q.bit_n + 3'h1;
                  if (q.bit_n == see_pkg::LAST_BIT)
                  begin
                     d.ack_ph = 1'b1;
                     d.drive = 1'b1; // RQ2
                     if (q.st == see_pkg::SEE_ST_DEV)
                     begin
                        if (!dev_match || busy_link)
                        begin
                           d.st = see_pkg::SEE_ST_IDLE; // RQ7 RQ10 RQ11
                           d.ack_ph = 1'b0;
                           d.drive = 1'b0;
                        end
                     end
                     else if (q.st == see_pkg::SEE_ST_ADDR)
                        d.ptr = rx_byte[see_pkg::IDX_W-1:0]; // RQ8 RQ22
                     else
                     begin
                        d.wr_addr = q.ptr; // RQ9
                        d.wr_data = rx_byte;
                        d.wr_tog = ~q.wr_tog;
                        d.ptr = page_inc(q.ptr); // RQ13 RQ15
                     end
                  end
               end
            end
            see_pkg::SEE_ST_RD:
            begin
               if (q.bit_n == see_pkg::LAST_BIT)
               begin
                  d.drive = 1'b0; // RQ25
                  d.bit_n = 3'h0;
                  d.st = see_pkg::SEE_ST_MACK;
               end
               else
               begin
                  d.sh = {q.sh[6:0], 1'b0};
                  d.drive = ~q.sh[6]; // RQ20 RQ25
                  d.bit_n = q.bit_n + 3'h1;
               end
            end
            see_pkg::SEE_ST_MACK:
            begin
               if (!sda_rise_q)
                  d = load_byte(d, rd_data); // RQ18
               else
               begin
                  d.st = see_pkg::SEE_ST_IDLE; // RQ19 RQ23
                  d.drive = 1'b0;
               end
            end
            default:
            begin
               d.st = see_pkg::SEE_ST_IDLE;
               d.drive = 1'b0;
            end
         endcase
      end
   end

   // state register, output changes after the falling edge
   always_ff @(negedge scl or posedge rst)
   begin
      if (rst)
         q <= LINK_RST;
      else
         q <= d; // RQ20
   end

   // ********************************************
   // outputs
   // ********************************************
   // open drain: level is always low, only the enable moves
   assign sda_o = 1'b0; // RQ25
   assign sda_oe = q.drive; // RQ25
   assign busy = busy_sys;

   // ********************************************
   // checks
   // ********************************************
   chk_start_dev_open: assert property ( // RQ21
      @(negedge scl) disable iff (rst)
      start_w |=> (q.st == see_pkg::SEE_ST_DEV) && !q.drive && (q.bit_n == 3'h0))
      else $error("start did not open device address phase");

   chk_addr_ack: assert property ( // RQ2
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_ADDR && !q.ack_ph && q.bit_n == see_pkg::LAST_BIT
         && quiet_w) |=> (q.drive && q.ack_ph) ##1 !q.drive)
      else $error("word address not acknowledged for one clock");

   chk_dev_match: assert property ( // RQ7
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_DEV && !q.ack_ph && q.bit_n == see_pkg::LAST_BIT
         && quiet_w && dev_match && !busy_link) |=> q.drive && q.ack_ph)
      else $error("matching device address not acknowledged");

   chk_dev_nomatch: assert property ( // RQ7
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_DEV && !q.ack_ph && q.bit_n == see_pkg::LAST_BIT
         && quiet_w && !dev_match) |=> (q.st == see_pkg::SEE_ST_IDLE) && !q.drive)
      else $error("foreign device address was acknowledged");

   chk_busy_noack: assert property ( // RQ11
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_DEV && !q.ack_ph && q.bit_n == see_pkg::LAST_BIT
         && quiet_w && busy_link) |=> !q.drive)
      else $error("acknowledge given while programming");

   chk_seq_next: assert property ( // RQ18
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_MACK && quiet_w && !sda_rise_q)
         |=> (q.st == see_pkg::SEE_ST_RD) && (q.sh == $past(rd_data))
         && (q.ptr == 7'($past(q.ptr) + 7'h01)))
      else $error("master acknowledge did not advance the read");

   chk_read_wrap: assert property ( // RQ14
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_MACK && quiet_w && !sda_rise_q && q.ptr == 7'h7f)
         |=> q.ptr == 7'h00)
      else $error("read counter did not wrap to zero");

   chk_page_wrap: assert property ( // RQ15
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_DATA && !q.ack_ph && q.bit_n == see_pkg::LAST_BIT
         && quiet_w && (q.ptr & PAGE_MASK) == PAGE_MASK)
         |=> (q.ptr == ($past(q.ptr) & ~PAGE_MASK)) && (q.wr_tog != $past(q.wr_tog)))
      else $error("write counter left its page");

   chk_nack_idle: assert property ( // RQ23
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_MACK && quiet_w && sda_rise_q)
         |=> (q.st == see_pkg::SEE_ST_IDLE) && !q.drive)
      else $error("master nack did not end the read");

   chk_rd_release: assert property ( // RQ16
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_RD && q.bit_n == see_pkg::LAST_BIT && quiet_w)
         |=> !q.drive && (q.st == see_pkg::SEE_ST_MACK))
      else $error("line not released for master acknowledge");

   chk_idle_release: assert property ( // RQ25
      @(negedge scl) disable iff (rst)
      (q.st == see_pkg::SEE_ST_IDLE) |-> !q.drive)
      else $error("line pulled low while idle");

   cov_seq_read: cover property (
      @(negedge scl) disable iff (rst)
      q.st == see_pkg::SEE_ST_MACK && quiet_w && !sda_rise_q);

   cov_write_byte: cover property (
      @(negedge scl) disable iff (rst)
      q.wr_tog != $past(q.wr_tog));

   cov_busy_poll: cover property (
      @(negedge scl) disable iff (rst)
      q.st == see_pkg::SEE_ST_DEV && q.bit_n == see_pkg::LAST_BIT && quiet_w
         && dev_match && busy_link);

   cov_cur_read: cover property (
      @(negedge scl) disable iff (rst)
      q.st == see_pkg::SEE_ST_DEV && q.ack_ph && q.sh[0] && quiet_w);

endmodule

`default_nettype wire

// ==== see_master.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********************************************
// two-wire bus master model
// ********************************************
module see_master
(
   output logic scl,
   output logic pull_low,
   input wire logic sda
);
   // bus idle, clock parked high
   initial
   begin
      scl = 1'b1;
      pull_low = 1'b0;
   end

   // start or repeated start, sda falls while scl high
   task automatic start();
      if (scl === 1'b0)
      begin
         #7 pull_low = 1'b0;
         #8 scl = 1'b1;
         #15;
      end
      pull_low = 1'b1;
      #15 scl = 1'b0;
   endtask

   // one clock: change sda in low phase, sample 7 ns after rising scl
   task automatic bit_x(input logic b, output logic s);
      #7 pull_low = ~b;
      #8 scl = 1'b1;
      #7 s = sda;
      #8 scl = 1'b0;
   endtask

   // eight bits msb first, then ninth clock returns the ack
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(d[i], s);
      end
      bit_x(1'b1, ack);
   endtask

   // eight bits from slave, then master ack or nack
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(nack, s);
   endtask

   // stop, sda rises while scl high, held long for the sync;
   // scl then parks low so the link sees the stop at a falling edge
   // and the next start gets a rising scl with sda high
   task automatic stop();
      #7 pull_low = 1'b1;
      #8 scl = 1'b1;
      #20 pull_low = 1'b0;
      #30 scl = 1'b0;
      #15;
   endtask
endmodule

`default_nettype wire

// ==== tb_see_eeprom.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_see_eeprom;
   logic clock;
   logic rst;
   logic scl;
   logic m_pull;
   logic sda_w;
   logic sda_o;
   logic sda_oe;
   logic busy;
   int failures;
   int checks;
   logic [7:0] wr_a [6] = '{8'h05, 8'h7f, 8'h00, 8'h01, 8'h08, 8'h0f};
   logic [7:0] wr_d [6] = '{8'h3c, 8'hc3, 8'h11, 8'h22, 8'h55, 8'h44};
   logic [7:0] bad_a [4] = '{8'hb0, 8'ha2, 8'h20, 8'hae};

   // open-drain wire with pull-up
   assign sda_w = (sda_oe | m_pull) ? 1'b0 : 1'b1;

   see_eeprom #(.PROG_TIME_NS(1000), .PAGE_BYTES(8)) dut
   (
      .clock(clock),
      .rst(rst),
      .scl(scl),
      .sda_i(sda_w),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .busy(busy)
   );

   see_master m
   (
      .scl(scl),
      .pull_low(m_pull),
      .sda(sda_w)
   );

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ********************************************
   // compare and closing
   // ********************************************
   task automatic chk1(input string what, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ********************************************
   // scenarios
   // ********************************************
   task automatic t_reset();
      chk1("sda_oe idle", 1'b0, sda_oe);
      chk1("sda_o", 1'b0, sda_o);
      chk1("busy idle", 1'b0, busy);
   endtask

   // foreign device addresses get no ack
   task automatic t_bad_addr();
      logic ack;
      foreach (bad_a[i])
      begin
         m.start();
         m.wr_byte(bad_a[i], ack);
         chk1("bad addr ack", 1'b1, ack);
         m.stop();
      end
   endtask

   // byte write, then acknowledge polling until programmed
   task automatic t_write(input logic [7:0] a, input logic [7:0] d);
      logic ack;
      int k;
      m.start();
      m.wr_byte(8'ha0, ack);
      chk1("dev ack", 1'b0, ack);
      m.wr_byte(a, ack);
      chk1("addr ack", 1'b0, ack);
      m.wr_byte(d, ack);
      chk1("data ack", 1'b0, ack);
      m.stop();
      k = 0;
      while (busy !== 1'b1 && k < 20)
      begin
         @(negedge clock);
         k++;
      end
      chk1("busy after stop", 1'b1, busy);
      m.start();
      m.wr_byte(8'ha0, ack);
      chk1("poll while busy", 1'b1, ack);
      k = 0;
      while (ack !== 1'b0 && k < 10)
      begin
         m.stop();
         m.start();
         m.wr_byte(8'ha0, ack);
         k++;
      end
      m.stop();
      chk1("poll ack", 1'b0, ack);
   endtask

   // optional dummy write, then read n bytes, nack on the last
   task automatic t_read(input logic rnd, input logic [7:0] a, input logic [7:0] e [3],
                         input int n);
      logic ack;
      logic [7:0] d;
      if (rnd)
      begin
         m.start();
         m.wr_byte(8'ha0, ack);
         chk1("dummy dev ack", 1'b0, ack);
         m.wr_byte(a, ack);
         chk1("dummy addr ack", 1'b0, ack);
      end
      m.start();
      m.wr_byte(8'ha1, ack);
      chk1("read dev ack", 1'b0, ack);
      for (int i = 0; i < n; i++)
      begin
         m.rd_byte(i == n - 1, d);
         chk8("read data", e[i], d);
      end
      m.stop();
      chk1("released after read", 1'b0, sda_oe);
   endtask

   // ********************************************
   // main sequence and watchdog
   // ********************************************
   initial
   begin
      failures = 0;
      checks = 0;
      rst = 1'b1;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      t_reset();
      t_bad_addr();
      foreach (wr_a[i])
      begin
         t_write(wr_a[i], wr_d[i]);
      end
      t_read(1'b0, 8'h00, '{8'h55, 8'h00, 8'h00}, 1);
      t_read(1'b1, 8'h7f, '{8'hc3, 8'h11, 8'h00}, 2);
      t_read(1'b0, 8'h00, '{8'h22, 8'h00, 8'h00}, 1);
      t_read(1'b1, 8'h05, '{8'h3c, 8'h00, 8'h00}, 1);
      results();
   end

   initial
   begin
      #200000;
      failures++;
      $display("MISMATCH watchdog expected done seen hang");
      results();
   end
endmodule

`default_nettype wire
